//--- core/rsm_pkg.sv
// Purpose: constants for the reset-cause and supply monitor register block
// Assumes: 8-bit special-function register port, single 50 MHz clock
// Notes: both registers are reachable from every register page
package rsm_pkg;
    localparam logic [7:0] RSM_ADDR_RESET_CAUSE = 8'hEF;
    localparam logic [7:0] RSM_ADDR_SUPPLY_CTRL = 8'hFF;
    // reset_cause bit positions
    localparam int RSM_BIT_USB = 7;
    localparam int RSM_BIT_FLASH = 6;
    localparam int RSM_BIT_CMP = 5;
    localparam int RSM_BIT_SW = 4;
    localparam int RSM_BIT_WDT = 3;
    localparam int RSM_BIT_CLK = 2;
    localparam int RSM_BIT_POR = 1;
    localparam int RSM_BIT_PIN = 0;
    // supply_monitor_control bit positions
    localparam int RSM_BIT_MON_EN = 7;
    localparam int RSM_BIT_MON_STAT = 6;
    // values taken at power-on: power-on flag set, monitor on and selected, everything else off
    localparam logic [7:0] RSM_POR_CAUSE = 8'h02;
    localparam logic RSM_POR_MON_EN = 1'b1;
    localparam logic RSM_POR_SRC_EN = 1'b1;
    localparam logic [7:0] RSM_ZERO = 8'h00;
    // cause codes presented with a system reset
    typedef enum logic [2:0] {
        RSM_CAUSE_PIN,
        RSM_CAUSE_WDT,
        RSM_CAUSE_FLASH,
        RSM_CAUSE_CLK,
        RSM_CAUSE_CMP,
        RSM_CAUSE_USB,
        RSM_CAUSE_SW,
        RSM_CAUSE_MON
    } rsm_cause_e;
endpackage

//--- core/rsm_reset_regs.sv
// Purpose: reset-cause flags, reset source selection and supply monitor control
// Assumes: i_reset is power-on only; system resets arrive as i_sys_rst_pulse with a cause
// Notes: flags are replaced by each system reset; enables live in the always-on domain and survive system resets
module rsm_reset_regs (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_sys_rst_pulse,
    input wire rsm_pkg::rsm_cause_e i_sys_rst_cause,
    input wire logic i_supply_above_thresh,
    output logic o_sw_reset_req,
    output logic o_usb_reset_en,
    output logic o_cmp_reset_en,
    output logic o_clk_loss_en,
    output logic o_mon_reset_en,
    output logic o_supply_monitor_enable
);
    import rsm_pkg::*;

    // register decode
    logic sel_cause;
    logic sel_supply;
    logic wr_cause;
    logic wr_supply;
    logic rd_cause;
    logic rd_supply;

    // reset-cause flags and their next value
    logic [7:0] cause_q;
    logic [7:0] cause_d;

    // reset source selections
    logic usb_en_q;
    logic cmp_en_q;
    logic clk_en_q;
    logic mon_src_q;

    // supply monitor control
    logic mon_en_q;

    // software force request
    logic sw_req_d;
    logic sw_req_q;

    // supply comparator synchroniser
    logic supply_s1_q;
    logic supply_s2_q;

    // read words, one per register
    logic [7:0] cause_word;
    logic [7:0] supply_word;

    // page-independent decode: address alone selects the register
    // no page input exists, so no page can hide either register
    assign sel_cause = (i_sfr_addr == RSM_ADDR_RESET_CAUSE);
    assign sel_supply = (i_sfr_addr == RSM_ADDR_SUPPLY_CTRL);
    assign wr_cause = i_sfr_wr && sel_cause;
    assign wr_supply = i_sfr_wr && sel_supply;
    assign rd_cause = i_sfr_rd && sel_cause;
    assign rd_supply = i_sfr_rd && sel_supply;

    // supply comparator is analog, so synchronise before use
    // status lags the pin by two edges; reads during that gap see the old level
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            supply_s1_q <= 1'b0;
            supply_s2_q <= 1'b0;
        end else begin
            supply_s1_q <= i_supply_above_thresh;
            supply_s2_q <= supply_s1_q;
        end
    end

    // one-hot cause on each system reset; power-on flag set by a monitor cause and cleared by all others
    always_comb begin
        cause_d = RSM_ZERO;
        case (i_sys_rst_cause)
            RSM_CAUSE_PIN: cause_d[RSM_BIT_PIN] = 1'b1;
            RSM_CAUSE_WDT: cause_d[RSM_BIT_WDT] = 1'b1;
            RSM_CAUSE_FLASH: cause_d[RSM_BIT_FLASH] = 1'b1;
            RSM_CAUSE_CLK: cause_d[RSM_BIT_CLK] = 1'b1;
            RSM_CAUSE_CMP: cause_d[RSM_BIT_CMP] = 1'b1;
            RSM_CAUSE_USB: cause_d[RSM_BIT_USB] = 1'b1;
            RSM_CAUSE_SW: cause_d[RSM_BIT_SW] = 1'b1;
            RSM_CAUSE_MON: cause_d[RSM_BIT_POR] = 1'b1;
            default: cause_d = RSM_ZERO;
        endcase
    end

    // flags are status only: software writes never alter them
    // a whole byte is replaced, so stale flags from older resets never linger
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cause_q <= RSM_POR_CAUSE;
        end else if (i_sys_rst_pulse) begin
            cause_q <= cause_d;
        end
    end

    // source selections live outside the system reset so they survive it
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            usb_en_q <= 1'b0;
        end else if (wr_cause) begin
            usb_en_q <= i_sfr_wdata[RSM_BIT_USB];
        end
    end

    // comparator output is active low; the selection only gates it
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cmp_en_q <= 1'b0;
        end else if (wr_cause) begin
            cmp_en_q <= i_sfr_wdata[RSM_BIT_CMP];
        end
    end

    // writing 0 turns the clock-loss detector off again
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            clk_en_q <= 1'b0;
        end else if (wr_cause) begin
            clk_en_q <= i_sfr_wdata[RSM_BIT_CLK];
        end
    end

    // monitor selected at power-on to guard the supply ramp
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            mon_src_q <= RSM_POR_SRC_EN;
        end else if (wr_cause) begin
            mon_src_q <= i_sfr_wdata[RSM_BIT_POR];
        end
    end

    // force is a one-cycle request; the reset it causes reports back as SW cause
    assign sw_req_d = wr_cause && i_sfr_wdata[RSM_BIT_SW];

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sw_req_q <= 1'b0;
        end else begin
            sw_req_q <= sw_req_d;
        end
    end

    // monitor enable; on after power-on, untouched by system resets
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            mon_en_q <= RSM_POR_MON_EN;
        end else if (wr_supply) begin
            mon_en_q <= i_sfr_wdata[RSM_BIT_MON_EN];
        end
    end

    // cause word carries flags only; the write-side selections never echo back
    assign cause_word = cause_q;

    // unused supply bits read as zero
    always_comb begin
        supply_word = RSM_ZERO;
        supply_word[RSM_BIT_MON_EN] = mon_en_q;
        supply_word[RSM_BIT_MON_STAT] = supply_s2_q;
    end

    // read path is separate from the write path
    // combinational so a read completes in the cycle it is asked
    always_comb begin
        o_sfr_rdata = RSM_ZERO;
        if (rd_cause) begin
            o_sfr_rdata = cause_word;
        end else if (rd_supply) begin
            o_sfr_rdata = supply_word;
        end
    end

    assign o_sw_reset_req = sw_req_q;
    assign o_usb_reset_en = usb_en_q;
    assign o_cmp_reset_en = cmp_en_q;
    assign o_clk_loss_en = clk_en_q;

    // no gating against an unsettled monitor: software must wait first
    // gating here would hide a real supply dip during the settle time
    assign o_mon_reset_en = mon_src_q;
    assign o_supply_monitor_enable = mon_en_q;
endmodule

//--- dv/rsm_reset_regs_checker.sv
// Purpose: port assertions for rsm_reset_regs
// Assumes: one clock, i_reset synchronous active high
// Notes: bound to the design at the foot
module rsm_checker (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic i_sys_rst_pulse,
    input wire logic i_supply_above_thresh,
    input wire logic o_sw_reset_req,
    input wire logic o_usb_reset_en,
    input wire logic o_cmp_reset_en,
    input wire logic o_clk_loss_en,
    input wire logic o_mon_reset_en,
    input wire logic o_supply_monitor_enable
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    wire wr_ef = i_sfr_wr && (i_sfr_addr == 8'hEF);
    wire wr_ff = i_sfr_wr && (i_sfr_addr == 8'hFF);
    wire [3:0] src = {i_sfr_wdata[7], i_sfr_wdata[5], i_sfr_wdata[2:1]};
    wire [4:0] en = {o_usb_reset_en, o_cmp_reset_en, o_clk_loss_en, o_mon_reset_en, o_supply_monitor_enable};
    a_sw_req_pulse: assert property (wr_ef && i_sfr_wdata[4] |=> o_sw_reset_req)
        else $error("sw request missing");
    a_sw_req_cause: assert property (o_sw_reset_req |-> $past(wr_ef && i_sfr_wdata[4]))
        else $error("sw request unasked");
    a_src_en_write: assert property (wr_ef |=> en[4:1] == $past(src))
        else $error("source enable wrong");
    a_mon_en_write: assert property (wr_ff |=> o_supply_monitor_enable == $past(i_sfr_wdata[7]))
        else $error("monitor enable wrong");
    a_en_hold: assert property (!i_sfr_wr |=> $stable(en)) else $error("enable moved");
    a_cause_onehot: assert property (i_sfr_rd && i_sfr_addr == 8'hEF |-> $onehot(o_sfr_rdata))
        else $error("cause not single");
    a_unmapped_zero: assert property (i_sfr_rd && i_sfr_addr != 8'hEF && i_sfr_addr != 8'hFF |-> o_sfr_rdata == 8'h00)
        else $error("unmapped read");
    a_status_sync: assert property (i_sfr_rd && i_sfr_addr == 8'hFF && !$past(i_reset) && !$past(i_reset, 2)
        |-> o_sfr_rdata == {o_supply_monitor_enable, $past(i_supply_above_thresh, 2), 6'h00}) else $error("supply read");
    c_sw_force: cover property (wr_ef && i_sfr_wdata[4]);
    c_cause: cover property (i_sys_rst_pulse);
    c_supply_up: cover property (i_sfr_rd && i_sfr_addr == 8'hFF && o_sfr_rdata[6]);
endmodule
bind rsm_reset_regs rsm_checker u_chk (.i_ref_clk, .i_reset, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
    .o_sfr_rdata, .i_sys_rst_pulse, .i_supply_above_thresh, .o_sw_reset_req, .o_usb_reset_en, .o_cmp_reset_en,
    .o_clk_loss_en, .o_mon_reset_en, .o_supply_monitor_enable);

//--- dv/test_rsm_reset_regs.sv
// Purpose: self-checking bench for rsm_reset_regs
// Assumes: inputs change on the falling edge, seed fixed
// Notes: every cause code, random enable writes, reset at the end of the run
module test_rsm_reset_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import rsm_pkg::*;
    logic i_ref_clk = 0, i_reset = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_sys_rst_pulse = 0, i_supply_above_thresh = 1;
    logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata, d;
    rsm_cause_e i_sys_rst_cause = RSM_CAUSE_PIN;
    logic o_sw_reset_req, o_usb_reset_en, o_cmp_reset_en, o_clk_loss_en, o_mon_reset_en, o_supply_monitor_enable;
    int bad_count = 0, num_checks = 0, cyc = 0;
    int bit_of [8] = '{RSM_BIT_PIN, RSM_BIT_WDT, RSM_BIT_FLASH, RSM_BIT_CLK, RSM_BIT_CMP, RSM_BIT_USB, RSM_BIT_SW, RSM_BIT_POR};
    rsm_reset_regs dut (.i_ref_clk, .i_reset, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
        .i_sys_rst_pulse, .i_sys_rst_cause, .i_supply_above_thresh, .o_sw_reset_req, .o_usb_reset_en,
        .o_cmp_reset_en, .o_clk_loss_en, .o_mon_reset_en, .o_supply_monitor_enable);
    always #10 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (++cyc > 4000) begin
        bad_count++;
        give_verdict();
    end
    function automatic logic [7:0] exp_cause(int k);
        return 8'h01 << bit_of[k];
    endfunction
    task automatic chk(input logic [7:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(negedge i_ref_clk);
        {i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, a, v};
        @(negedge i_ref_clk);
        i_sfr_wr = 0;
    endtask
    // read data is combinational, so it is looked at just after the drive
    task automatic rd(input logic [7:0] a, exp, input string what);
        @(negedge i_ref_clk);
        {i_sfr_rd, i_sfr_addr} = {1'b1, a};
        #1 chk(o_sfr_rdata, exp, what);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h2103));
        repeat (16) @(negedge i_ref_clk);
        i_reset = 0;
        rd(8'hEF, 8'h02, "power-on cause");
        rd(8'hFF, 8'hC0, "supply control");
        for (int k = 0; k < 8; k++) begin
            @(negedge i_ref_clk);
            {i_sys_rst_pulse, i_sys_rst_cause} = {1'b1, rsm_cause_e'(k)};
            @(negedge i_ref_clk);
            i_sys_rst_pulse = 0;
            rd(8'hEF, exp_cause(k), "cause");
        end
        for (int n = 0; n < 12; n++) begin
            d = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom);
            d[1] = d[1] & d[7];
            wr(8'hFF, d);
            repeat (4) @(negedge i_ref_clk);
            wr(8'hEF, d);
            chk({4'h0, o_usb_reset_en, o_cmp_reset_en, o_clk_loss_en, o_mon_reset_en}, {4'h0, d[7], d[5], d[2:1]}, "src en");
            chk({7'h0, o_sw_reset_req}, {7'h0, d[4]}, "sw request");
            i_supply_above_thresh = d[0];
            rd(8'hEF, 8'h02, "cause kept");
            chk({7'h0, o_sw_reset_req}, 8'h00, "sw request end");
            rd({1'b0, d[6:0]}, 8'h00, "unmapped");
            rd(8'hFF, {d[7], d[0], 6'h00}, "supply");
        end
        i_reset = 1;
        repeat (2) @(negedge i_ref_clk);
        i_reset = 0;
        chk({3'h0, o_usb_reset_en, o_cmp_reset_en, o_clk_loss_en, o_mon_reset_en, o_supply_monitor_enable}, 8'h03, "reset en");
        give_verdict();
    end
endmodule
